// ### flash_seq_pkg.sv
// Shared constants for the flash self-programming sequencer
package flash_seq_pkg;

  // ****************************************
  // Page geometry
  // ****************************************
  localparam int WORD_BITS = 5;
  localparam int PAGE_WORDS = 32;
  localparam int PAGE_BITS = 10;
  localparam int PTR_WORD_LSB = 1;
  localparam int PTR_PAGE_LSB = 6;
  localparam int DATA_BITS = 16;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // ****************************************
  // APB register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] VALID_OFFSET = 8'h08;

  // ****************************************
  // Store-program control register
  // ****************************************
  localparam logic [7:0] CMD_LOAD = 8'h01;
  localparam logic [7:0] CMD_ERASE = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h05;
  localparam logic [7:0] CMD_CLEAR = 8'h11;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_ERASING = 1;
  localparam int ST_WRITING = 2;
  localparam int ST_FUSE_OK = 3;
  localparam int ST_PENDING = 4;
  localparam int ST_EXPIRED = 5;

  // ****************************************
  // Timing
  // ****************************************
  localparam logic [2:0] SPM_WINDOW_CYCLES = 3'h4;
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int PROG_TIME_MIN_NS = 3700000;
  localparam int PROG_CYCLES =
    (PROG_TIME_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ERASE,
    SEQ_STREAM,
    SEQ_PROGRAM
  } seq_state_type;

endpackage : flash_seq_pkg

// ### page_buffer.sv
// Temporary page buffer storage with registered read data
`timescale 1ns/1ns
module page_buffer (
  input wire logic clock_i,                                   // System clock
  input wire logic wr_en_i,                                   // Write strobe
  input wire logic [flash_seq_pkg::WORD_BITS-1:0] wr_addr_i,  // Write word index
  input wire logic [flash_seq_pkg::DATA_BITS-1:0] wr_data_i,  // Write data
  input wire logic [flash_seq_pkg::WORD_BITS-1:0] rd_addr_i,  // Read word index
  output logic [flash_seq_pkg::DATA_BITS-1:0] rd_data_o       // Read data, one cycle late
);

  logic [flash_seq_pkg::DATA_BITS-1:0] mem [flash_seq_pkg::PAGE_WORDS];

  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    rd_data_o <= mem[rd_addr_i];
  end

endmodule : page_buffer

// ### flash_self_program_sequencer.sv
// Flash self-programming sequencer: command window, page buffer, erase and write
`timescale 1ns/1ns
module flash_self_program_sequencer #(
  parameter int PROG_CYCLES = flash_seq_pkg::PROG_CYCLES
) (
  input wire logic clock_i,                                     // System clock, 20 MHz
  input wire logic rst_i,                                       // Sync reset, active high
  input wire logic psel,                                        // APB select
  input wire logic penable,                                     // APB enable
  input wire logic pwrite,                                      // APB direction
  input wire logic [7:0] paddr,                                 // APB byte address
  input wire logic [31:0] pwdata,                               // APB write data
  output logic [31:0] prdata,                                   // APB read data
  output logic pready,                                          // APB ready
  output logic pslverr,                                         // APB error
  input wire logic self_program_enable_fuse_i,                  // Fuse pin, 0 = programmed
  input wire logic spm_i,                                       // Store-program strobe
  input wire logic [15:0] pointer_i,                            // Flash address pointer
  input wire logic [15:0] data_word_registers_i,                // Word to load
  output logic cpu_halt_o,                                      // Stall CPU execution
  output logic flash_erase_o,                                   // Erase pulse to array
  output logic flash_wstrobe_o,                                 // Word program strobe
  output logic [flash_seq_pkg::PAGE_BITS-1:0] flash_page_o,     // Target page
  output logic [flash_seq_pkg::WORD_BITS-1:0] flash_word_o,     // Target word
  output logic [flash_seq_pkg::DATA_BITS-1:0] flash_wdata_o     // Word to program
);

  // ****************************************
  // Pointer decoding
  // ****************************************
  function automatic logic [flash_seq_pkg::WORD_BITS-1:0] word_field(input logic [15:0] p);
    word_field = p[flash_seq_pkg::PTR_WORD_LSB +: flash_seq_pkg::WORD_BITS];
  endfunction : word_field

  function automatic logic [flash_seq_pkg::PAGE_BITS-1:0] page_field(input logic [15:0] p);
    page_field = p[flash_seq_pkg::PTR_PAGE_LSB +: flash_seq_pkg::PAGE_BITS];
  endfunction : page_field

  // Status snapshot; the busy bits let software poll instead of counting cycles
  function automatic logic [31:0] status_word(input flash_seq_pkg::seq_state_type s,
                                              input logic fuse_n,
                                              input logic pending,
                                              input logic lapsed);
    status_word = 32'h0000_0000;
    status_word[flash_seq_pkg::ST_BUSY] = s != flash_seq_pkg::SEQ_IDLE;
    status_word[flash_seq_pkg::ST_ERASING] = s == flash_seq_pkg::SEQ_ERASE;
    status_word[flash_seq_pkg::ST_WRITING] = (s == flash_seq_pkg::SEQ_STREAM) ||
                                             (s == flash_seq_pkg::SEQ_PROGRAM);
    status_word[flash_seq_pkg::ST_FUSE_OK] = !fuse_n;
    status_word[flash_seq_pkg::ST_PENDING] = pending;
    status_word[flash_seq_pkg::ST_EXPIRED] = lapsed;
  endfunction : status_word

  flash_seq_pkg::seq_state_type state_reg;
  logic fuse_meta_reg;
  logic fuse_sync_reg;
  logic [7:0] store_program_control_reg;
  logic [2:0] window_reg;
  logic expired_reg;
  logic [flash_seq_pkg::PAGE_WORDS-1:0] valid_reg;
  logic [31:0] time_reg;
  logic [flash_seq_pkg::WORD_BITS-1:0] stream_idx_reg;
  logic stream_out_reg;
  logic [flash_seq_pkg::WORD_BITS-1:0] stream_word_reg;
  logic [flash_seq_pkg::DATA_BITS-1:0] buf_rd_data;
  logic wr_access;
  logic ctrl_write;
  logic spm_taken;
  logic do_load;
  logic do_erase;
  logic do_write;
  logic do_clear;
  logic prog_done;
  logic erase_done;
  logic stream_done;

  // ****************************************
  // Fuse synchroniser
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      fuse_meta_reg <= 1'b1;
      fuse_sync_reg <= 1'b1;
    end else begin
      fuse_meta_reg <= self_program_enable_fuse_i;
      fuse_sync_reg <= fuse_meta_reg;
    end
  end

  // ****************************************
  // APB slave, zero wait states
  // ****************************************
  assign pready = 1'b1;
  assign wr_access = psel && penable && pwrite;
  // Control writes are refused while an operation runs; the CPU is halted then anyway
  assign ctrl_write = wr_access && (paddr == flash_seq_pkg::CTRL_OFFSET) &&
                      (state_reg == flash_seq_pkg::SEQ_IDLE);

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      pslverr = !((paddr == flash_seq_pkg::CTRL_OFFSET) ||
                  (!pwrite && (paddr == flash_seq_pkg::STATUS_OFFSET)) ||
                  (!pwrite && (paddr == flash_seq_pkg::VALID_OFFSET)));
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        flash_seq_pkg::CTRL_OFFSET: prdata <= {24'h00_0000, store_program_control_reg};
        flash_seq_pkg::STATUS_OFFSET: begin
          prdata <= status_word(state_reg, fuse_sync_reg, window_reg != 3'h0, expired_reg);
        end
        flash_seq_pkg::VALID_OFFSET: prdata <= valid_reg;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Command window
  // ****************************************
  // The instruction is accepted only in the cycles counted down after the command write
  assign spm_taken = spm_i && (window_reg != 3'h0) && !fuse_sync_reg;
  assign do_load = spm_taken && (store_program_control_reg == flash_seq_pkg::CMD_LOAD);
  assign do_erase = spm_taken && (store_program_control_reg == flash_seq_pkg::CMD_ERASE);
  assign do_write = spm_taken && (store_program_control_reg == flash_seq_pkg::CMD_WRITE);
  assign do_clear = spm_taken && (store_program_control_reg == flash_seq_pkg::CMD_CLEAR);

  // Code is cleared on acceptance or lapse so a stale code can never be replayed
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      store_program_control_reg <= flash_seq_pkg::CTRL_RESET;
    end else if (ctrl_write) begin
      store_program_control_reg <= pwdata[7:0];
    end else if (spm_taken || (window_reg == 3'h1)) begin
      store_program_control_reg <= flash_seq_pkg::CTRL_RESET;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      window_reg <= 3'h0;
    end else if (ctrl_write) begin
      window_reg <= flash_seq_pkg::SPM_WINDOW_CYCLES;
    end else if (spm_taken) begin
      window_reg <= 3'h0;
    end else if (window_reg != 3'h0) begin
      window_reg <= window_reg - 3'h1;
    end
  end

  // Window closes with no instruction: the command is dropped
  always_ff @(posedge clock_i) begin
    if (rst_i || ctrl_write) begin
      expired_reg <= 1'b0;
    end else if (!spm_taken && (window_reg == 3'h1)) begin
      expired_reg <= 1'b1;
    end
  end

  // ****************************************
  // Page buffer and its loaded-word map
  // ****************************************
  page_buffer u_page_buffer (
    .clock_i(clock_i),
    .wr_en_i(do_load),
    .wr_addr_i(word_field(pointer_i)),
    .wr_data_i(data_word_registers_i),
    .rd_addr_i(stream_idx_reg),
    .rd_data_o(buf_rd_data)
  );

  // Unloaded words stream out as erased so the array keeps them blank
  always_ff @(posedge clock_i) begin
    if (rst_i || do_clear || prog_done) begin
      valid_reg <= '0;
    end else if (do_load) begin
      valid_reg[word_field(pointer_i)] <= 1'b1;
    end
  end

  // ****************************************
  // Erase and write sequencing
  // ****************************************
  assign prog_done = (state_reg == flash_seq_pkg::SEQ_PROGRAM) && (time_reg == 32'h0000_0001);
  assign erase_done = (state_reg == flash_seq_pkg::SEQ_ERASE) && (time_reg == 32'h0000_0001);
  assign stream_done = (state_reg == flash_seq_pkg::SEQ_STREAM) &&
    (stream_idx_reg == flash_seq_pkg::WORD_BITS'(flash_seq_pkg::PAGE_WORDS - 1));

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= flash_seq_pkg::SEQ_IDLE;
    end else begin
      unique case (state_reg)
        flash_seq_pkg::SEQ_IDLE: begin
          if (do_erase) begin
            state_reg <= flash_seq_pkg::SEQ_ERASE;
          end else if (do_write) begin
            state_reg <= flash_seq_pkg::SEQ_STREAM;
          end
        end
        flash_seq_pkg::SEQ_ERASE: begin
          if (erase_done) begin
            state_reg <= flash_seq_pkg::SEQ_IDLE;
          end
        end
        flash_seq_pkg::SEQ_STREAM: begin
          if (stream_done) begin
            state_reg <= flash_seq_pkg::SEQ_PROGRAM;
          end
        end
        flash_seq_pkg::SEQ_PROGRAM: begin
          if (prog_done) begin
            state_reg <= flash_seq_pkg::SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // One down-counter times both the erase and the programming pulse
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      time_reg <= 32'h0000_0000;
    end else if (do_erase || stream_done) begin
      time_reg <= 32'(PROG_CYCLES);
    end else if (time_reg != 32'h0000_0000) begin
      time_reg <= time_reg - 32'h0000_0001;
    end
  end

  // Walks the buffer once per page write; parked at zero otherwise
  always_ff @(posedge clock_i) begin
    if (rst_i || (state_reg != flash_seq_pkg::SEQ_STREAM)) begin
      stream_idx_reg <= '0;
    end else begin
      stream_idx_reg <= stream_idx_reg + 1'b1;
    end
  end

  // Read data lags the index by one cycle, so the stream output is delayed to match
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stream_out_reg <= 1'b0;
      stream_word_reg <= '0;
    end else begin
      stream_out_reg <= state_reg == flash_seq_pkg::SEQ_STREAM;
      stream_word_reg <= stream_idx_reg;
    end
  end

  // ****************************************
  // Flash array outputs
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flash_erase_o <= 1'b0;
    end else begin
      flash_erase_o <= do_erase;
    end
  end

  // Page latched at acceptance: later pointer changes cannot retarget a running operation
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flash_page_o <= '0;
    end else if (do_erase || do_write) begin
      flash_page_o <= page_field(pointer_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flash_wstrobe_o <= 1'b0;
      flash_word_o <= '0;
      flash_wdata_o <= flash_seq_pkg::ERASED_WORD;
    end else begin
      flash_wstrobe_o <= stream_out_reg;
      flash_word_o <= stream_word_reg;
      flash_wdata_o <= valid_reg[stream_word_reg] ? buf_rd_data : flash_seq_pkg::ERASED_WORD;
    end
  end

  // Halt from the accepting cycle on so the CPU never runs past the instruction
  assign cpu_halt_o = do_erase || do_write ||
                      (state_reg != flash_seq_pkg::SEQ_IDLE);

endmodule : flash_self_program_sequencer

// ### flash_seq_asserts.sv
// Port-level assertions for the flash self-programming sequencer
`timescale 1ns/1ns
module flash_seq_asserts #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic clock_i,                    // System clock
  input wire logic rst_i,                      // Sync reset
  input wire logic psel,                       // APB select
  input wire logic penable,                    // APB enable
  input wire logic pwrite,                     // APB direction
  input wire logic [7:0] paddr,                // APB address
  input wire logic pready,                     // APB ready
  input wire logic self_program_enable_fuse_i, // Fuse pin
  input wire logic spm_i,                      // Store-program strobe
  input wire logic [15:0] pointer_i,           // Address pointer
  input wire logic cpu_halt_o,                 // CPU stall
  input wire logic flash_erase_o,              // Erase pulse
  input wire logic flash_wstrobe_o,            // Word strobe
  input wire logic [9:0] flash_page_o          // Target page
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic [15:0] pointer_reg;
  logic [6:0] run_reg;
  logic [16:0] halt_reg;
  // ****************************************
  // Helper counters and pointer delay register
  // ****************************************
  always_ff @(posedge clock_i) begin
    pointer_reg <= pointer_i;
  end
  always_ff @(posedge clock_i) begin
    run_reg <= (rst_i || !flash_wstrobe_o) ? 7'h00 : run_reg + 7'h01;
  end
  // Wide enough for the full-length programming time
  always_ff @(posedge clock_i) begin
    halt_reg <= (rst_i || !cpu_halt_o) ? 17'h00000 : halt_reg + 17'h00001;
  end
  fuse_block_a: assert property (self_program_enable_fuse_i [*4] |-> !$rose(cpu_halt_o))
    else $error("halt rose with the fuse unprogrammed");
  halt_cause_a: assert property ($rose(cpu_halt_o) |-> spm_i)
    else $error("halt rose without a store-program strobe");
  erase_halt_a: assert property ($rose(flash_erase_o) |-> cpu_halt_o [*8])
    else $error("cpu released during erase");
  halt_length_a: assert property ($fell(cpu_halt_o) |-> halt_reg >= PROG_CYCLES)
    else $error("halt shorter than programming time");
  erase_page_a: assert property ($rose(flash_erase_o) |-> flash_page_o == pointer_reg[15:6])
    else $error("erase page not from page field");
  strobe_halt_a: assert property (flash_wstrobe_o |-> cpu_halt_o)
    else $error("word strobe while cpu runs");
  page_run_a: assert property ($fell(flash_wstrobe_o) |-> run_reg == 7'h20)
    else $error("page write not 32 strobes");
  window_end_a: assert property ((psel && penable && pwrite && pready && paddr == 8'h00
    && !cpu_halt_o) ##1 !spm_i [*4] ##1 spm_i |-> !cpu_halt_o)
    else $error("late strobe accepted");
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("no ready in access phase");
endmodule : flash_seq_asserts
bind flash_self_program_sequencer flash_seq_asserts #(.PROG_CYCLES(PROG_CYCLES))
  i_flash_seq_asserts (.clock_i, .rst_i, .psel, .penable, .pwrite, .paddr, .pready,
  .self_program_enable_fuse_i, .spm_i, .pointer_i, .cpu_halt_o, .flash_erase_o,
  .flash_wstrobe_o, .flash_page_o);

// ### cpu_model.sv
// CPU stand-in that issues the store-program strobe after a command write
`timescale 1ns/1ns
module cpu_model (
  input wire logic clock_i,     // System clock
  input wire logic cmd_wr_i,    // Control write taken on the bus
  input wire logic [2:0] lag_i, // Edges to the strobe, 0 = never
  output logic spm_o            // Store-program strobe
);
  logic [2:0] cnt_reg;
  initial begin
    cnt_reg = 3'h0;
    spm_o = 1'b0;
  end
  // A lag of 5 lets the window lapse on purpose
  always @(posedge clock_i) begin
    if (cmd_wr_i) begin
      cnt_reg <= lag_i;
      spm_o <= (lag_i == 3'h1);
    end else begin
      cnt_reg <= (cnt_reg > 3'h1) ? cnt_reg - 3'h1 : 3'h0;
      spm_o <= (cnt_reg == 3'h2);
    end
  end
endmodule : cpu_model

// ### testbench.sv
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  logic clock_i, rst_i, psel, penable, pwrite, pready, pslverr, fuse, spm, cmd_wr, rerr;
  logic halt, erase, wstb;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] ptr, dat, wdata;
  logic [15:0] wdat [32];
  logic [9:0] page, erase_page;
  logic [4:0] word;
  logic [2:0] lag;
  int num_errors, num_checks, cycles, n_strobe, n_erase, n_halt;
  assign cmd_wr = psel & penable & pwrite & pready & (paddr == flash_seq_pkg::CTRL_OFFSET);
  flash_self_program_sequencer #(.PROG_CYCLES(20)) i_flash_self_program_sequencer (
    .clock_i(clock_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .self_program_enable_fuse_i(fuse), .spm_i(spm), .pointer_i(ptr),
    .data_word_registers_i(dat), .cpu_halt_o(halt), .flash_erase_o(erase),
    .flash_wstrobe_o(wstb), .flash_page_o(page), .flash_word_o(word),
    .flash_wdata_o(wdata));
  cpu_model i_cpu_model (.clock_i(clock_i), .cmd_wr_i(cmd_wr), .lag_i(lag), .spm_o(spm));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // ****************************************
  // Monitor and hang guard
  // ****************************************
  always @(posedge clock_i) begin
    cycles++;
    if (wstb === 1'b1) begin
      wdat[word] = wdata;
      n_strobe++;
    end
    if (erase === 1'b1) begin
      n_erase++;
      erase_page = page;
    end
    if (halt === 1'b1) n_halt++;
    if (cycles > 4000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (pready !== 1'b1) begin
      @(posedge clock_i);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmd(input logic [7:0] c, input logic [2:0] l);
    lag <= l;
    apb(1'b1, flash_seq_pkg::CTRL_OFFSET, {24'h0, c});
    repeat (6) @(posedge clock_i);
    while (halt !== 1'b0) begin
      @(posedge clock_i);
    end
  endtask : cmd
  task automatic load(input logic [4:0] w, input logic [15:0] d, input logic [2:0] l);
    ptr <= {10'h009, w, 1'b0};
    dat <= d;
    cmd(flash_seq_pkg::CMD_LOAD, l);
  endtask : load
  task automatic t_regs();
    apb(1'b0, flash_seq_pkg::STATUS_OFFSET, 32'h0);
    `CHK(rdat, 32'h0000_0008)
    apb(1'b0, flash_seq_pkg::CTRL_OFFSET, 32'h0);
    `CHK(rdat, 32'h0)
    apb(1'b0, flash_seq_pkg::VALID_OFFSET, 32'h0);
    `CHK(rdat, 32'h0)
    apb(1'b1, 8'h0c, 32'h1);
    `CHK(rerr, 1'b1)
    apb(1'b1, flash_seq_pkg::STATUS_OFFSET, 32'h1);
    `CHK(rerr, 1'b1)
    $display("done regs");
  endtask : t_regs
  task automatic t_load();
    load(5'h03, 16'h1303, 3'h4);
    load(5'h00, 16'h1000, 3'h1);
    load(5'h1f, 16'h131f, 3'h2);
    apb(1'b0, flash_seq_pkg::VALID_OFFSET, 32'h0);
    `CHK(rdat, 32'h80000009)
    $display("done load");
  endtask : t_load
  task automatic t_erase();
    ptr <= {10'h005, 5'h1f, 1'b1};
    dat <= 16'hbeef;
    n_erase = 0;
    n_halt = 0;
    cmd(flash_seq_pkg::CMD_ERASE, 3'h4);
    `CHK(n_erase, 1)
    `CHK(erase_page, 10'h005)
    `CHK(n_halt >= 20, 1'b1)
    apb(1'b0, flash_seq_pkg::VALID_OFFSET, 32'h0);
    `CHK(rdat, 32'h80000009)
    $display("done erase");
  endtask : t_erase
  task automatic t_write();
    ptr <= {10'h005, 6'h00};
    n_strobe = 0;
    cmd(flash_seq_pkg::CMD_WRITE, 3'h1);
    `CHK(n_strobe, 32)
    `CHK(wdat[0], 16'h1000)
    `CHK(wdat[3], 16'h1303)
    `CHK(wdat[31], 16'h131f)
    `CHK(wdat[7], flash_seq_pkg::ERASED_WORD)
    `CHK(page, 10'h005)
    apb(1'b0, flash_seq_pkg::VALID_OFFSET, 32'h0);
    `CHK(rdat, 32'h0)
    $display("done write");
  endtask : t_write
  task automatic t_expire();
    n_erase = 0;
    cmd(flash_seq_pkg::CMD_ERASE, 3'h5);
    `CHK(n_erase, 0)
    apb(1'b0, flash_seq_pkg::CTRL_OFFSET, 32'h0);
    `CHK(rdat, 32'h0)
    apb(1'b0, flash_seq_pkg::STATUS_OFFSET, 32'h0);
    `CHK(rdat[flash_seq_pkg::ST_EXPIRED], 1'b1)
    $display("done expire");
  endtask : t_expire
  task automatic t_reset();
    load(5'h04, 16'h4444, 3'h1);
    apb(1'b0, flash_seq_pkg::VALID_OFFSET, 32'h0);
    `CHK(rdat, 32'h0000_0010)
    rst_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    apb(1'b0, flash_seq_pkg::VALID_OFFSET, 32'h0);
    `CHK(rdat, 32'h0)
    $display("done reset");
  endtask : t_reset
  task automatic t_clear_fuse();
    load(5'h07, 16'h7777, 3'h3);
    cmd(flash_seq_pkg::CMD_CLEAR, 3'h2);
    apb(1'b0, flash_seq_pkg::VALID_OFFSET, 32'h0);
    `CHK(rdat, 32'h0)
    fuse <= 1'b1;
    repeat (4) @(posedge clock_i);
    load(5'h02, 16'h2222, 3'h1);
    apb(1'b0, flash_seq_pkg::VALID_OFFSET, 32'h0);
    `CHK(rdat, 32'h0)
    n_erase = 0;
    cmd(flash_seq_pkg::CMD_ERASE, 3'h1);
    `CHK(n_erase, 0)
    `CHK(halt, 1'b0)
    fuse <= 1'b0;
    $display("done clear and fuse");
  endtask : t_clear_fuse
  initial begin
    {rst_i, psel, penable, pwrite, fuse} = 5'b10000;
    {paddr, pwdata, ptr, dat, lag} = '0;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    t_regs();
    t_load();
    t_erase();
    t_write();
    t_expire();
    t_reset();
    t_clear_fuse();
    tally_and_finish();
  end
endmodule : testbench
